// ### alu_flags_pkg.sv
package alu_flags_pkg;

    // ======================================================================
    // data path widths and flag field positions
    // ======================================================================
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned FLAG_W        = 5;
    localparam int unsigned CARRY_BIT     = 0;
    localparam int unsigned HALF_BIT      = 1;
    localparam int unsigned ZERO_BIT      = 2;
    localparam int unsigned OVERFLOW_BIT  = 3;
    localparam int unsigned NEGATIVE_BIT  = 4;
    localparam int unsigned ROT_LEFT_HALF = 3;
    localparam int unsigned ROT_RIGHT_HALF = 4;

    // ======================================================================
    // register map, byte addresses on the bus
    // ======================================================================
    localparam int unsigned APB_ADDR_W   = 12;
    localparam int unsigned APB_DATA_W   = 32;
    localparam logic [11:0] FLAGS_OFFSET = 12'h000;
    localparam logic [11:0] CONFIG_OFFSET = 12'h004;
    localparam logic [11:0] ADDR_STAT_OFFSET = 12'h008;

    localparam int unsigned EXT_ISA_BIT      = 0;
    localparam int unsigned MODE_OK_BIT      = 0;
    localparam int unsigned MODE_REFUSED_BIT = 1;

    // ======================================================================
    // values after reset
    // ======================================================================
    localparam logic [4:0] FLAGS_RESET   = 5'h00;
    localparam logic       EXT_ISA_RESET = 1'b0;

    // ======================================================================
    // operations and addressing modes
    // ======================================================================
    typedef enum logic [4:0] {
        add_accumulator_file_op      = 5'h00,
        add_literal_op               = 5'h01,
        subtract_literal_op          = 5'h02,
        subtract_accumulator_file_op = 5'h03,
        rotate_right_op              = 5'h04,
        rotate_left_op               = 5'h05,
        and_op                       = 5'h06,
        or_op                        = 5'h07,
        xor_op                       = 5'h08,
        clear_file_op                = 5'h09,
        bit_clear_op                 = 5'h0a,
        bit_set_op                   = 5'h0b,
        nibble_swap_op               = 5'h0c,
        file_to_file_move_op         = 5'h0d,
        accumulator_store_op         = 5'h0e
    } op_t;

    typedef enum logic [2:0] {
        mode_inherent      = 3'h0,
        mode_literal       = 3'h1,
        mode_direct        = 3'h2,
        mode_indirect      = 3'h3,
        mode_indexed_offset = 3'h4
    } addr_mode_t;

    // widen a narrow register onto the bus, upper bits zero
    function automatic logic [31:0] bus_word(input logic [7:0] v);
        bus_word = {24'h000000, v};
    endfunction

endpackage

// ### flag_calc_if.sv
`timescale 1ns/1ps
`default_nettype none

interface flag_calc_if;
    import alu_flags_pkg::*;

    op_t        op;
    logic [7:0] a;
    logic [7:0] b;
    logic       carry_in;
    logic [7:0] result;
    logic [4:0] flags_new;
    logic [4:0] flags_touched;

    modport calc (
        input  op,
        input  a,
        input  b,
        input  carry_in,
        output result,
        output flags_new,
        output flags_touched
    );

    modport user (
        output op,
        output a,
        output b,
        output carry_in,
        input  result,
        input  flags_new,
        input  flags_touched
    );

endinterface

`default_nettype wire

// ### alu_flag_calc.sv
`timescale 1ns/1ps
`default_nettype none

module alu_flag_calc
    import alu_flags_pkg::*;
(
    flag_calc_if.calc fc            // operands in, result and flags out
);

    // ======================================================================
    // adder with carry taps: {carry, half carry, sum}
    // ======================================================================
    function automatic logic [9:0] add_taps(input logic [7:0] x,
                                            input logic [7:0] y,
                                            input logic       cin);
        logic [4:0] low;
        logic [8:0] full;
        low  = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
        full = {1'b0, x} + {1'b0, y} + {8'h00, cin};
        add_taps = {full[8], low[4], full[7:0]};
    endfunction

    logic [7:0] addend;
    logic       sub_sel;
    logic [9:0] sum_taps;
    logic       signed_ovf;

    always_comb begin
        sub_sel = (fc.op == subtract_literal_op) ||
                  (fc.op == subtract_accumulator_file_op);
        addend  = sub_sel ? ~fc.b : fc.b;
        sum_taps = add_taps(fc.a, addend, sub_sel);
        signed_ovf = (fc.a[7] == addend[7]) &&
                     (sum_taps[7] != fc.a[7]);
    end

    // ======================================================================
    // result and flag selection
    // ======================================================================
    always_comb begin
        fc.result        = fc.a;
        fc.flags_new     = 5'h00;
        fc.flags_touched = 5'h00;
        unique case (fc.op)
            add_accumulator_file_op, add_literal_op,
            subtract_literal_op, subtract_accumulator_file_op: begin
                fc.result = sum_taps[7:0];
                fc.flags_new[CARRY_BIT]    = sum_taps[9];
                fc.flags_new[HALF_BIT]     = sum_taps[8];
                fc.flags_new[OVERFLOW_BIT] = signed_ovf;
                fc.flags_touched = 5'h1f;
            end
            rotate_right_op: begin
                fc.result = {fc.carry_in, fc.a[7:1]};
                fc.flags_new[CARRY_BIT] = fc.a[0];
                fc.flags_new[HALF_BIT]  = fc.a[ROT_RIGHT_HALF];
                fc.flags_touched = 5'h17;
            end
            rotate_left_op: begin
                fc.result = {fc.a[6:0], fc.carry_in};
                fc.flags_new[CARRY_BIT] = fc.a[7];
                fc.flags_new[HALF_BIT]  = fc.a[ROT_LEFT_HALF];
                fc.flags_touched = 5'h17;
            end
            and_op: begin
                fc.result = fc.a & fc.b;
                fc.flags_touched = 5'h14;
            end
            or_op: begin
                fc.result = fc.a | fc.b;
                fc.flags_touched = 5'h14;
            end
            xor_op: begin
                fc.result = fc.a ^ fc.b;
                fc.flags_touched = 5'h14;
            end
            clear_file_op: begin
                fc.result = 8'h00;
                fc.flags_touched = 5'h04;
            end
            bit_clear_op: fc.result = fc.a & ~fc.b;
            bit_set_op: fc.result = fc.a | fc.b;
            nibble_swap_op: fc.result = {fc.a[3:0], fc.a[7:4]};
            file_to_file_move_op: fc.result = fc.a;
            accumulator_store_op: fc.result = fc.b;
            default: fc.result = fc.a;
        endcase
        fc.flags_new[NEGATIVE_BIT] = fc.result[7];
        fc.flags_new[ZERO_BIT]     = (fc.result == 8'h00);
    end

endmodule

`default_nettype wire

// ### alu_status_flags.sv
`timescale 1ns/1ps
`default_nettype none

module alu_status_flags
    import alu_flags_pkg::*;
(
    input  wire logic        pclk,          // bus and core clock
    input  wire logic        presetn,       // async reset, active low
    input  wire logic [11:0] paddr,         // apb byte address
    input  wire logic        psel,          // apb select
    input  wire logic        penable,       // apb access phase
    input  wire logic        pwrite,        // apb write
    input  wire logic [31:0] pwdata,        // apb write data
    input  wire logic [3:0]  pstrb,         // apb byte strobes
    output logic      [31:0] prdata,        // apb read data
    output logic             pready,        // apb ready
    output logic             pslverr,       // apb error, unmapped address
    input  wire logic        op_valid,      // one op this cycle
    input  wire op_t         op_code,       // operation
    input  wire logic        op_dest_flags, // destination is flag register
    input  wire logic [7:0]  op_a,          // file operand or minuend
    input  wire logic [7:0]  op_b,          // accumulator or literal
    output logic      [7:0]  result_data,   // result for write-back
    output logic             result_we,     // write-back strobe
    output logic      [4:0]  flag_bits,     // current flags
    input  wire logic        mem_valid,     // addressing mode check request
    input  wire addr_mode_t  mem_mode,      // requested addressing mode
    output logic             mem_mode_ok,   // mode legal, one-cycle answer
    output logic             mem_mode_done  // answer strobe
);

    // ======================================================================
    // flag computation
    // ======================================================================
    flag_calc_if fc_bus ();

    logic [4:0] flags_reg;
    logic [4:0] flags_next;
    logic       ext_isa_reg;
    logic       mode_ok_reg;
    logic       mode_refused_reg;

    assign fc_bus.op       = op_code;
    assign fc_bus.a        = op_a;
    assign fc_bus.b        = op_b;
    assign fc_bus.carry_in = flags_reg[CARRY_BIT];

    alu_flag_calc u_calc (
        .fc (fc_bus)
    );

    // ======================================================================
    // apb decode
    // ======================================================================
    logic        setup_phase;
    logic        access_done;
    logic        hit_flags;
    logic        hit_config;
    logic        hit_stat;
    logic        hit_any;
    logic        wr_lane0;
    logic [31:0] read_word;

    always_comb begin
        setup_phase = psel && !penable;
        access_done = psel && penable && pready;
        hit_flags   = (paddr == FLAGS_OFFSET);
        hit_config  = (paddr == CONFIG_OFFSET);
        hit_stat    = (paddr == ADDR_STAT_OFFSET);
        hit_any     = hit_flags || hit_config || hit_stat;
        wr_lane0    = access_done && pwrite && pstrb[0] && !pslverr;
        read_word   = 32'h00000000;
        if (hit_flags) begin
            read_word = bus_word({3'b000, flags_reg});
        end else if (hit_config) begin
            read_word = bus_word({7'h00, ext_isa_reg});
        end else if (hit_stat) begin
            read_word = bus_word({6'h00, mode_refused_reg, mode_ok_reg});
        end
    end

    // ready and read data come from the setup cycle: zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup_phase;
            pslverr <= setup_phase && !hit_any;
            if (setup_phase && !pwrite) begin
                prdata <= read_word;
            end
        end
    end

    // ======================================================================
    // flag register
    // ======================================================================
    always_comb begin
        flags_next = flags_reg;
        if (wr_lane0 && hit_flags) begin
            flags_next = pwdata[4:0];
        end
        // a core op outranks a bus write in the same cycle
        if (op_valid) begin
            if (op_dest_flags && (fc_bus.flags_touched != 5'h00)) begin
                flags_next = (flags_reg & ~fc_bus.flags_touched) |
                             (fc_bus.flags_new & fc_bus.flags_touched);
            end else if (op_dest_flags) begin
                flags_next = fc_bus.result[4:0];
            end else begin
                flags_next = (flags_reg & ~fc_bus.flags_touched) |
                             (fc_bus.flags_new & fc_bus.flags_touched);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_bits <= FLAGS_RESET;
        end else begin
            flag_bits <= flags_next;
        end
    end

    // ======================================================================
    // result write-back
    // ======================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_data <= 8'h00;
            result_we   <= 1'b0;
        end else begin
            result_we <= op_valid && !op_dest_flags;
            if (op_valid) begin
                result_data <= fc_bus.result;
            end
        end
    end

    // ======================================================================
    // configuration and addressing mode check
    // ======================================================================
    logic mode_legal;

    always_comb begin
        unique case (mem_mode)
            mode_inherent, mode_literal,
            mode_direct, mode_indirect: mode_legal = 1'b1;
            mode_indexed_offset: mode_legal = ext_isa_reg;
            default: mode_legal = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_isa_reg <= EXT_ISA_RESET;
        end else if (wr_lane0 && hit_config) begin
            ext_isa_reg <= pwdata[EXT_ISA_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ok_reg   <= 1'b0;
            mem_mode_ok   <= 1'b0;
            mem_mode_done <= 1'b0;
        end else begin
            mem_mode_done <= mem_valid;
            mem_mode_ok   <= mem_valid && mode_legal;
            if (mem_valid) begin
                mode_ok_reg <= mode_legal;
            end
        end
    end

    // sticky refusal; a new refusal wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_refused_reg <= 1'b0;
        end else if (mem_valid && !mode_legal) begin
            mode_refused_reg <= 1'b1;
        end else if (wr_lane0 && hit_stat && pwdata[MODE_REFUSED_BIT]) begin
            mode_refused_reg <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ### alu_flags_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================================================
// port checker
// ======================================================================
module alu_flags_checker
    import alu_flags_pkg::*;
(
    input wire logic        pclk,          // clock
    input wire logic        presetn,       // reset, active low
    input wire logic [11:0] paddr,         // address
    input wire logic        psel,          // select
    input wire logic        pwrite,        // write
    input wire logic [31:0] prdata,        // read data
    input wire logic        pready,        // ready
    input wire logic        op_valid,      // op strobe
    input wire op_t         op_code,       // op
    input wire logic        op_dest_flags, // dest flags
    input wire logic [7:0]  op_a,          // operand a
    input wire logic [7:0]  op_b,          // operand b
    input wire logic [7:0]  result_data,   // result
    input wire logic        result_we,     // write-back
    input wire logic [4:0]  flag_bits,     // flags
    input wire logic        mem_valid,     // mode request
    input wire addr_mode_t  mem_mode,      // mode
    input wire logic        mem_mode_ok,   // mode legal
    input wire logic        mem_mode_done  // mode answer
);
    logic [8:0] sum_q;
    logic [4:0] half_q;
    logic [7:0] a_q;
    logic       plain;
    logic       arith;
    assign plain = op_valid && !op_dest_flags;
    assign arith = plain && (op_code <= xor_op);
    // operands of the op just taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum_q  <= 9'h000;
            half_q <= 5'h00;
            a_q    <= 8'h00;
        end else begin
            sum_q  <= {1'b0, op_a} + {1'b0, op_b};
            half_q <= {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
            a_q    <= op_a;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_UPPER_ZERO: assert property (psel && pready && !pwrite
        && paddr == FLAGS_OFFSET |-> prdata[31:5] == 27'h0000000)
        else $error("flag read upper bits set");
    AST_DEST_NO_WB: assert property (op_valid && op_dest_flags
        |=> !result_we) else $error("write-back to flag register");
    AST_NEG: assert property (arith
        |=> flag_bits[4] == result_data[7]) else $error("negative wrong");
    AST_ZERO: assert property (arith
        |=> flag_bits[2] == (result_data == 8'h00)) else $error("zero wrong");
    AST_KEEP: assert property (plain && op_code >= bit_clear_op
        |=> $stable(flag_bits)) else $error("flags changed");
    AST_CLR: assert property (op_valid && op_dest_flags
        && op_code == clear_file_op |=> flag_bits == ($past(flag_bits)
        | 5'h04)) else $error("clear of flags wrong");
    AST_CARRY: assert property (plain && op_code == add_literal_op
        |=> flag_bits[0] == sum_q[8]) else $error("carry wrong");
    AST_HALF: assert property (plain && op_code == add_literal_op
        |=> flag_bits[1] == half_q[4]) else $error("half carry wrong");
    AST_ROT: assert property (plain && op_code == rotate_left_op
        |=> flag_bits[1:0] == {a_q[3], a_q[7]}) else $error("rotate wrong");
    AST_MODE: assert property (mem_valid && mem_mode <= mode_indirect
        |=> mem_mode_done && mem_mode_ok) else $error("mode refused");
    cover property (plain && op_code == subtract_literal_op);
    cover property (op_valid && op_dest_flags);
    cover property (mem_valid && mem_mode == mode_indexed_offset);
endmodule

bind alu_status_flags alu_flags_checker i_chk (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .op_valid(op_valid), .op_code(op_code), .op_dest_flags(op_dest_flags),
    .op_a(op_a), .op_b(op_b), .result_data(result_data),
    .result_we(result_we), .flag_bits(flag_bits), .mem_valid(mem_valid),
    .mem_mode(mem_mode), .mem_mode_ok(mem_mode_ok),
    .mem_mode_done(mem_mode_done)
);
`default_nettype wire

// ### wb_sink.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================================================
// write-back path of the core
// ======================================================================
module wb_sink (
    input  wire logic       pclk,     // clock
    input  wire logic       presetn,  // reset, active low
    input  wire logic       wr_en,    // write-back strobe
    input  wire logic [7:0] wr_data,  // write-back data
    output var  logic [7:0] file_q,   // last stored value
    output var  int         wr_count  // writes seen
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            file_q   <= 8'h00;
            wr_count <= 0;
        end else if (wr_en) begin
            file_q   <= wr_data;
            wr_count <= wr_count + 1;
        end
    end
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import alu_flags_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb, st;
    logic        op_valid, op_dest_flags, result_we, mem_valid;
    logic        mem_mode_ok, mem_mode_done, m_we, pend;
    op_t         op_code;
    addr_mode_t  mem_mode;
    logic [7:0]  op_a, op_b, result_data, file_q, m_res;
    logic [4:0]  flag_bits, m_flags;
    int          wr_count, m_wb, fail_count, compares, seed;

    always #2 pclk = ~pclk;

    alu_status_flags i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .op_valid(op_valid), .op_code(op_code), .op_dest_flags(op_dest_flags),
        .op_a(op_a), .op_b(op_b), .result_data(result_data),
        .result_we(result_we), .flag_bits(flag_bits), .mem_valid(mem_valid),
        .mem_mode(mem_mode), .mem_mode_ok(mem_mode_ok),
        .mem_mode_done(mem_mode_done));
    wb_sink i_sink (.pclk(pclk), .presetn(presetn), .wr_en(result_we),
        .wr_data(result_data), .file_q(file_q), .wr_count(wr_count));

    task automatic test_done();
        if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, ad, wd, st};
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count assumed: only the watchdog ends a hung access
        do @(posedge pclk); while (pready !== 1'b1);
        rd = {prdata[31:1], prdata[0] ^ (pslverr === 1'b1)};
        {psel, penable} <= 2'b00;
    endtask

    task automatic mode_chk(input logic [2:0] m, input logic ext);
        int n;
        @(posedge pclk);
        mem_valid <= 1'b1;
        mem_mode  <= addr_mode_t'(m);
        @(posedge pclk);
        mem_valid <= 1'b0;
        n = 0;
        do begin @(posedge pclk); n++; end while (mem_mode_done !== 1'b1 && n < 8);
        cmp(mem_mode_done, 1'b1);
        cmp(mem_mode_ok, m < 4 || (m == 4 && ext));
    endtask

    // reference flags and result of one op
    task automatic model(input op_t o, input logic [7:0] a, b, input logic d);
        logic [8:0] s;
        logic [4:0] h, f, t;
        logic [7:0] y, r;
        logic       sb;
        sb = (o == subtract_literal_op) || (o == subtract_accumulator_file_op);
        y = sb ? ~b : b;
        s = {1'b0, a} + {1'b0, y} + {8'h00, sb};
        h = {1'b0, a[3:0]} + {1'b0, y[3:0]} + {4'h0, sb};
        {f, t} = {5'h00, 5'h14};
        case (o)
            add_accumulator_file_op, add_literal_op, subtract_literal_op,
            subtract_accumulator_file_op: begin
                r = s[7:0];
                f[3] = (a[7] == y[7]) && (r[7] != a[7]);
                {f[1:0], t} = {h[4], s[8], 5'h1f};
            end
            rotate_left_op: {r, f[1:0], t} = {a[6:0], m_flags[0], a[3], a[7], 5'h17};
            rotate_right_op: {r, f[1:0], t} = {m_flags[0], a[7:1], a[4], a[0], 5'h17};
            and_op: r = a & b;
            or_op: r = a | b;
            xor_op: r = a ^ b;
            clear_file_op: {r, t} = {8'h00, 5'h04};
            bit_clear_op: {r, t} = {a & ~b, 5'h00};
            bit_set_op: {r, t} = {a | b, 5'h00};
            nibble_swap_op: {r, t} = {a[3:0], a[7:4], 5'h00};
            file_to_file_move_op: {r, t} = {a, 5'h00};
            default: {r, t} = {b, 5'h00};
        endcase
        {f[4], f[2]} = {r[7], r == 8'h00};
        f = (f & t) | (m_flags & ~t);
        if (d && t == 5'h00) f = r[4:0];
        {m_flags, m_we} = {f, !d};
        if (!d) m_res = r;
        if (!d) m_wb++;
    endtask

    task automatic check_op();
        cmp(flag_bits, m_flags);
        cmp(result_we, m_we);
        if (m_we) cmp(result_data, m_res);
    endtask

    task automatic issue(input op_t o, input logic [7:0] a, b, input logic d);
        @(posedge pclk);
        {op_valid, op_a, op_b, op_dest_flags} <= {1'b1, a, b, d};
        op_code <= o;
        #1;
        if (pend) check_op();
        model(o, a, b, d);
        pend = 1'b1;
    endtask

    initial begin
        #100000;
        fail_count++;
        test_done();
    end

    initial begin
        logic [31:0] rd;
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {op_valid, op_dest_flags, op_a, op_b, mem_valid, pend} = '0;
        op_code = add_literal_op;
        mem_mode = mode_inherent;
        {st, pstrb} = 8'hff;
        {m_flags, m_res, m_we, m_wb, fail_count, compares, seed} = {14'h0, 96'h0, 32'd23};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, FLAGS_OFFSET, 0, rd);
        cmp(rd, 32'h0);
        apb(1, FLAGS_OFFSET, 32'hffffffff, rd);
        st = 4'he;
        apb(1, FLAGS_OFFSET, 0, rd);
        st = 4'hf;
        apb(0, FLAGS_OFFSET, 0, rd);
        cmp(rd, 32'h1f);
        m_flags = 5'h1f;
        apb(0, 12'h00c, 0, rd);
        cmp(rd, 32'h1);
        for (int e = 0; e < 2; e++) begin
            apb(1, CONFIG_OFFSET, e, rd);
            for (int m = 0; m < 8; m++) mode_chk(m[2:0], e[0]);
        end
        apb(0, ADDR_STAT_OFFSET, 0, rd);
        cmp(rd, 32'h2);
        apb(1, ADDR_STAT_OFFSET, 32'h2, rd);
        apb(0, ADDR_STAT_OFFSET, 0, rd);
        cmp(rd, 32'h0);
        issue(add_accumulator_file_op, 8'h0f, 8'h01, 0);
        issue(subtract_literal_op, 8'h00, 8'h01, 0);
        issue(add_literal_op, 8'h7f, 8'h01, 0);
        issue(subtract_accumulator_file_op, 8'h80, 8'h01, 0);
        issue(clear_file_op, 8'h00, 8'h00, 1);
        issue(rotate_left_op, 8'h88, 8'h00, 0);
        issue(rotate_right_op, 8'h11, 8'h00, 0);
        issue(add_literal_op, 8'hff, 8'h01, 1);
        issue(bit_set_op, 8'h00, 8'h15, 1);
        repeat (300) issue(op_t'({$random(seed)} % 15), 8'($random(seed)),
            8'($random(seed)), ($random(seed) & 3) == 0);
        @(posedge pclk);
        op_valid <= 1'b0;
        #1;
        check_op();
        // the sink stores the last write-back one edge later
        @(posedge pclk);
        #1;
        cmp(wr_count, m_wb);
        cmp(file_q, m_res);
        test_done();
    end
endmodule
`default_nettype wire
